// [rtl/daq_pkg.sv]
package daq_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXPAN = 8'h04;
  localparam logic [7:0] ADDR_DOUT = 8'h08;
  localparam logic [7:0] ADDR_DIN = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_CNT0 = 8'h20;
  localparam logic [7:0] ADDR_CNT1 = 8'h24;
  localparam logic [7:0] ADDR_CNT2 = 8'h28;

  // Control register fields.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 1;
  localparam int CTRL_MUX_LSB = 4;

  // Expansion control fields.
  localparam int EXP_CHAN_LSB = 0;
  localparam int EXP_GAIN_LSB = 4;
  localparam int EXP_DOUT_BIT = 7;

  // Interrupt status bits.
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_EXT_BIT = 1;

  // Reset values.
  localparam logic [7:0] EXPAN_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'hFFFF;

  // Conversion timing.
  localparam int CONV_TIME_NS = 35000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_CYCLES = 4;

  // Host oscillator divided by 32, approximated by a fixed divide of the bus clock.
  localparam int OSC_FREQ_HZ = 14318180;
  localparam int CLK_FREQ_HZ = 200000000;
  localparam int OSC_DIV = CLK_FREQ_HZ / (OSC_FREQ_HZ / 32);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_t;

endpackage

// [rtl/daq_card_control_logic.sv]
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
//
// Contract
// - Sample then convert to a 12-bit result.
// - Conversion finishes within 35 microseconds.
// - Software picks one of eight inputs.
// - Expansion byte, four bits pick channel.
// - Three expansion bits pick the gain.
// - Last expansion bit is software output.
// - Transducer card uses three channel bits.
// - Eight discrete lines, direction by jumper.
// - Three independent 16-bit down counters.
// - Counter one clocked by oscillator over 32.
// - Counter one clocks two, zero by jumper.
// - Counters decrement on falling clock edge.
// - Timer jumper lets timer start conversions.
// - Interrupt source chosen by jumper.
// - Interrupt forwarded only when software enables.
// - Reset, conversion start, selection write clear interrupt.
//
// Bus-side control of a plug-in acquisition card: conversion sequencing,
// input and expansion selection, a three-stage counter chain and the interrupt.
// Every register answers with zero wait states; read data is prepared in the
// setup cycle so that it stands for the whole access cycle.
// Jumper inputs are treated as static levels; changing one mid-run is legal,
// but the change only takes hold at the next event that it steers.
module daq_card_control_logic
  import daq_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter front end.
  output logic [2:0] mux_select,
  output logic sample_hold,
  input wire logic [11:0] adc_data,
  // Triggers and jumpers.
  input wire logic external_trigger,
  input wire logic timer_trigger_position,
  input wire logic counter_zero_clock_jumper,
  input wire logic irq_source_external,
  input wire logic external_irq,
  input wire logic counter0_clk,
  // Expansion control byte.
  output logic [3:0] expansion_output_lines,
  output logic [2:0] expansion_gain_select_lines,
  output logic expansion_dout,
  // Discrete lines.
  input wire logic [7:0] discrete_io_dir,
  input wire logic [7:0] discrete_io_lines_in,
  output logic [7:0] discrete_io_lines_out,
  output logic [7:0] discrete_io_lines_oe,
  // Counter outputs and interrupt.
  output logic [2:0] counter_out,
  output logic irq
);

  logic irq_en_q;
  logic [2:0] mux_q;
  logic [7:0] expan_q;
  logic [7:0] dout_q;
  logic [11:0] result_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  // Counter chain state: live counts, reload values and the sampled clock levels.
  // The sampled levels feed the falling-edge detectors of the chain.
  logic [15:0] cnt_q [3];
  logic [15:0] reload_q [3];
  logic [2:0] cclk_q;
  logic [2:0] cclk_in;
  logic [2:0] cfall;
  logic [2:0] load_req;
  logic [7:0] div_q;
  logic osc_tick;
  logic osc_half_q;
  // Conversion sequencer state and its shared down counter.
  // One counter serves both the sample window and the conversion window.
  conv_state_t state_q;
  logic [15:0] conv_cnt_q;
  logic busy_q;
  logic conv_done;
  logic conv_start;
  logic timer_fall;
  // Decoded bus strobes and trigger qualifiers.
  // All but ext_q are combinational and valid only in the access cycle; ext_q is a register.
  logic wr;
  logic rd;
  logic sw_start;
  logic sel_write;
  logic ext_q;

  // Write strobe for one register offset, true only in the access cycle of a write.
  // Sharing this decode between the start, selection and counter-load strobes makes those side effects land on one edge.
  function automatic logic reg_wr(input logic wr_i, input logic [7:0] addr_i, input logic [7:0] offs_i);
    reg_wr = wr_i && (addr_i == offs_i);
  endfunction

  // Bus strobes: the slave answers in the first access cycle.
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign sw_start = reg_wr(wr, paddr, ADDR_CTRL) && pwdata[CTRL_START_BIT];
  assign sel_write = reg_wr(wr, paddr, ADDR_CTRL) || reg_wr(wr, paddr, ADDR_EXPAN);

  // Timer trigger is the falling edge of counter one's output when the jumper selects it.
  // Counter two's clock is that same output, so its edge detector is reused here.
  // The detector already compares the old and new level, so no further qualifier
  // on the output itself is wanted: the new level is low whenever the edge is seen.
  // A trigger that arrives while a conversion runs is dropped, as a start while busy is.
  assign timer_fall = cfall[2];
  assign conv_start = (state_q == ST_IDLE) && (sw_start || (timer_trigger_position ? timer_fall
    : (external_trigger && !ext_q)));
  assign conv_done = (state_q == ST_CONVERT) && (conv_cnt_q == 16'h0000);

  // Bus answer registers.
  // Ready is raised for exactly the access cycle that follows each setup cycle.
  // Read data is latched in the setup cycle; it then holds until the next read,
  // so a slow master that samples late still sees the value of its own read.
  // Unmapped offsets read as zero and never raise an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata <= {25'h0, mux_q, 2'h0, irq_en_q, 1'b0};
          ADDR_EXPAN: prdata <= {24'h0, expan_q};
          ADDR_DOUT: prdata <= {24'h0, dout_q};
          ADDR_DIN: prdata <= {24'h0, discrete_io_lines_in};
          ADDR_RESULT: prdata <= {20'h0, result_q};
          ADDR_STATUS: prdata <= {31'h0, busy_q};
          ADDR_IRQ_STAT: prdata <= {30'h0, irq_stat_q};
          ADDR_IRQ_MASK: prdata <= {30'h0, irq_mask_q};
          ADDR_CNT0: prdata <= {16'h0, cnt_q[0]};
          ADDR_CNT1: prdata <= {16'h0, cnt_q[1]};
          ADDR_CNT2: prdata <= {16'h0, cnt_q[2]};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control, expansion and discrete output registers.
  // The start bit is not stored: it is a one-shot request decoded from the write.
  // The mask resets to all ones so that enabling interrupts alone is enough.
  // Writes to read-only or unmapped offsets fall through the default branch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= 1'b0;
      mux_q <= 3'h0;
      expan_q <= EXPAN_RESET;
      dout_q <= 8'h00;
      irq_mask_q <= 2'h3;
    end else if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          irq_en_q <= pwdata[CTRL_IRQ_EN_BIT];
          mux_q <= pwdata[CTRL_MUX_LSB +: 3];
        end
        ADDR_EXPAN: expan_q <= pwdata[7:0];
        ADDR_DOUT: dout_q <= pwdata[7:0];
        ADDR_IRQ_MASK: irq_mask_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Conversion sequencer: sample-and-hold, then a fixed conversion time.
  // The hold strobe rises on the edge that takes the start and falls on the edge
  // that captures the result, so it doubles as the busy indication.
  // The conversion window is counted so that the whole stretch, sample included,
  // stays inside the converter's worst-case time; shortening the parameter for
  // simulation keeps the same structure.
  // The external trigger is edge detected here; its history register updates
  // every cycle so that a level held through a conversion cannot retrigger.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      conv_cnt_q <= 16'h0000;
      busy_q <= 1'b0;
      sample_hold <= 1'b0;
      result_q <= 12'h000;
      ext_q <= 1'b0;
    end else begin
      ext_q <= external_trigger;
      case (state_q)
        ST_IDLE: begin
          if (conv_start) begin
            state_q <= ST_SAMPLE;
            busy_q <= 1'b1;
            sample_hold <= 1'b1;
            conv_cnt_q <= 16'(SAMPLE_CYCLES - 1);
          end
        end
        ST_SAMPLE: begin
          if (conv_cnt_q == 16'h0000) begin
            state_q <= ST_CONVERT;
            conv_cnt_q <= 16'(CONV_CYCLES_P - SAMPLE_CYCLES - 2);
          end else begin
            conv_cnt_q <= conv_cnt_q - 16'h0001;
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            state_q <= ST_IDLE;
            result_q <= adc_data;
            busy_q <= 1'b0;
            sample_hold <= 1'b0;
          end else begin
            conv_cnt_q <= conv_cnt_q - 16'h0001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Sticky interrupt status; set beats clear, conversion start and selection writes clear it.
  // Only the source picked by the jumper can set its bit; the other cannot be set and keeps its value until cleared.
  // A one written to a status bit clears it as well, for software that wants
  // to acknowledge without touching the selections.
  // A completion on the very edge of a clear keeps its bit, so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic set_i;
        logic clr_i;
        set_i = (i == IRQ_CONV_BIT) ? (conv_done && !irq_source_external)
          : (external_irq && irq_source_external);
        clr_i = conv_start || sel_write || (wr && paddr == ADDR_IRQ_STAT && pwdata[i]);
        if (set_i) begin
          irq_stat_q[i] <= 1'b1;
        end else if (clr_i) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt output gated by the enable and mask.
  // It is a level: it stays high while any unmasked bit stays set.
  // Disabling interrupts is a control write, so it also clears the pending bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_en_q && |(irq_stat_q & irq_mask_q);
    end
  end

  // Oscillator-over-32 enable: a square wave for counter one's clock.
  // The rate is a truncated integer divide of the bus clock, so the counter
  // chain runs slightly off the true oscillator rate; long timing intervals
  // drift by that ratio.
  // Only the divider runs free; everything it clocks sees one-cycle enables.
  assign osc_tick = (div_q == 8'(OSC_DIV / 2 - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      osc_half_q <= 1'b0;
    end else begin
      div_q <= osc_tick ? 8'h00 : div_q + 8'h01;
      if (osc_tick) begin
        osc_half_q <= !osc_half_q;
      end
    end
  end

  // Counter clock routing and falling-edge detection.
  // Counter zero takes either counter one's output or its own pin, by jumper.
  // The pin is sampled by the bus clock, so it must stay high and low for at
  // least one bus clock each to be counted.
  always_comb begin
    cclk_in[1] = osc_half_q;
    cclk_in[2] = counter_out[1];
    cclk_in[0] = counter_zero_clock_jumper ? counter_out[1] : counter0_clk;
  end
  assign cfall = cclk_q & ~cclk_in;
  assign load_req[0] = reg_wr(wr, paddr, ADDR_CNT0);
  assign load_req[1] = reg_wr(wr, paddr, ADDR_CNT1);
  assign load_req[2] = reg_wr(wr, paddr, ADDR_CNT2);

  // Three 16-bit down counters with reload; output toggles at terminal count.
  // A load restarts the count at once and wins over a clock edge in the same cycle.
  // Reload values of zero and one both give the shortest period.
  // The edge history resets low, matching the idle level of every clock source,
  // so no false edge follows reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cclk_q <= 3'h0;
      counter_out <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= CNT_RESET;
        reload_q[i] <= CNT_RESET;
      end
    end else begin
      cclk_q <= cclk_in;
      for (int i = 0; i < 3; i++) begin
        if (load_req[i]) begin
          reload_q[i] <= pwdata[15:0];
          cnt_q[i] <= pwdata[15:0];
        end else if (cfall[i]) begin
          if (cnt_q[i] <= 16'h0001) begin
            cnt_q[i] <= reload_q[i];
            counter_out[i] <= !counter_out[i];
          end else begin
            cnt_q[i] <= cnt_q[i] - 16'h0001;
          end
        end
      end
    end
  end

  // Pin outputs registered from the control state.
  // Each pin lags its register, and the line enables lag the jumpers, by one cycle, which keeps every output glitch free.
  // Direction of the discrete lines follows the jumpers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_select <= 3'h0;
      expansion_output_lines <= 4'h0;
      expansion_gain_select_lines <= 3'h0;
      expansion_dout <= 1'b0;
      discrete_io_lines_out <= 8'h00;
      discrete_io_lines_oe <= 8'h00;
    end else begin
      mux_select <= mux_q;
      expansion_output_lines <= expan_q[EXP_CHAN_LSB +: 4];
      expansion_gain_select_lines <= expan_q[EXP_GAIN_LSB +: 3];
      expansion_dout <= expan_q[EXP_DOUT_BIT];
      discrete_io_lines_out <= dout_q;
      discrete_io_lines_oe <= discrete_io_dir;
    end
  end

endmodule

// [testbench/daq_card_control_logic_chk.sv]
`timescale 1ns/1ps
module daq_chk
  import daq_pkg::*;
#(
  parameter int CONV_CYCLES_P = 20
) (
  // Clock, reset and bus.
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Converter, expansion byte, lines and interrupt.
  input wire logic [2:0] mux_select, expansion_gain_select_lines,
  input wire logic [3:0] expansion_output_lines,
  input wire logic sample_hold, expansion_dout, irq, irq_source_external,
  input wire logic [7:0] discrete_io_dir, discrete_io_lines_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic [15:0] busy_q;
  // Write strobe of the access phase.
  assign wr = psel && penable && pwrite;
  // Counts cycles of one busy stretch so its length can be bounded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 16'h0000;
    end else begin
      busy_q <= sample_hold ? busy_q + 16'h0001 : 16'h0000;
    end
  end
  // A start request while idle, then the busy flag rising soon after.
  sequence s_start; wr && paddr == ADDR_CTRL && pwdata[CTRL_START_BIT] && !sample_hold; endsequence
  sequence s_busy_up; ##[1:2] sample_hold; endsequence
  property p_start; s_start |-> s_busy_up; endproperty
  a_start: assert property (p_start) else $error("start did not raise busy");
  property p_bus; psel && !penable |=> pready; endproperty
  a_bus: assert property (p_bus) else $error("no ready in access cycle");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_exp; wr && paddr == ADDR_EXPAN |-> ##2 {expansion_dout, expansion_gain_select_lines,
    expansion_output_lines} == $past(pwdata[7:0], 2); endproperty
  a_exp: assert property (p_exp) else $error("expansion byte wrong");
  property p_mux; s_start |-> ##2 mux_select == $past(pwdata[CTRL_MUX_LSB +: 3], 2); endproperty
  a_mux: assert property (p_mux) else $error("input select wrong");
  property p_clr; wr && (paddr == ADDR_CTRL || paddr == ADDR_EXPAN) && !sample_hold && !$past(sample_hold)
    && !irq_source_external |-> ##[1:2] !irq; endproperty
  a_clr: assert property (p_clr) else $error("interrupt not cleared");
  property p_bound; busy_q <= CONV_CYCLES_P + SAMPLE_CYCLES + 4; endproperty
  a_bound: assert property (p_bound) else $error("conversion too long");
  property p_oe; $stable(discrete_io_dir) |=> discrete_io_lines_oe == $past(discrete_io_dir); endproperty
  a_oe: assert property (p_oe) else $error("line direction wrong");
endmodule

bind daq_card_control_logic daq_chk #(.CONV_CYCLES_P(CONV_CYCLES_P)) i_chk (.*);

// [testbench/daq_adc_model.sv]
`timescale 1ns/1ps
module daq_adc_model (
  // Clock and conversion strobe.
  input wire logic pclk,
  input wire logic sample_hold,
  // Code to present and converter output.
  input wire logic [11:0] code,
  output logic [11:0] adc_data
);
  logic [11:0] held_q;
  initial adc_data = 12'hA5A;
  // Holds the sampled code while busy; outside a conversion the bus churns.
  always @(posedge pclk) begin
    if (!sample_hold) begin
      held_q <= code;
      adc_data <= ~adc_data;
    end else begin
      adc_data <= held_q;
    end
  end
endmodule

// [testbench/daq_card_control_logic_test.sv]
`timescale 1ns/1ps
module daq_card_control_logic_test;
  import daq_pkg::*;
  localparam int CONV = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic external_trigger = 1'b0, timer_trigger_position = 1'b0, counter_zero_clock_jumper = 1'b0;
  logic irq_source_external = 1'b0, external_irq = 1'b0, counter0_clk = 1'b0;
  logic [7:0] paddr = 8'h00, discrete_io_dir = 8'h5A, discrete_io_lines_in = 8'hC3;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'h6B03AFB9;
  logic [11:0] code = 12'h000, adc_data;
  logic pready, pslverr, sample_hold, expansion_dout, irq;
  logic [2:0] mux_select, expansion_gain_select_lines, counter_out;
  logic [3:0] expansion_output_lines;
  logic [7:0] discrete_io_lines_out, discrete_io_lines_oe;
  logic [11:0] codes[$];
  int checked = 0, n_fail = 0, busy;
  daq_card_control_logic #(.CONV_CYCLES_P(CONV)) i_dut (.*);
  daq_adc_model i_adc (.pclk, .sample_hold, .code, .adc_data);
  initial forever #2.5 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic settle();
    @(posedge pclk);
    #1;
  endtask
  // One APB transfer; holds the request until ready is seen.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for busy to rise, then counts how long it stays up.
  task automatic waitdone();
    busy = 0;
    while (sample_hold !== 1'b1 && busy < 5) begin
      @(posedge pclk);
      busy++;
    end
    busy = 0;
    while (sample_hold === 1'b1 && busy < 500) begin
      @(posedge pclk);
      busy++;
    end
    #1;
  endtask
  // Software conversion on one input, then result, status and clearing.
  task automatic conv(input logic [2:0] m, input logic en);
    v = rnd();
    code <= v[11:0];
    codes.push_back(v[11:0]);
    bus(1'b1, ADDR_CTRL, {25'h0, m, 2'b00, en, 1'b1});
    waitdone();
    chk(mux_select, m);
    chk(busy > 0 && busy <= CONV, 1'b1);
    bus(1'b0, ADDR_RESULT, 32'h0);
    chk(rd, codes.pop_front());
    repeat (2) settle();
    chk(irq, en);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd[0], 1'b1);
    bus(1'b1, ADDR_EXPAN, 32'h0);
    repeat (2) settle();
    chk(irq, 1'b0);
  endtask
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk({expansion_dout, expansion_gain_select_lines, expansion_output_lines}, EXPAN_RESET);
    bus(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk(rd, 32'h3);
    bus(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    repeat (4) begin
      v = rnd();
      bus(1'b1, ADDR_EXPAN, v);
      settle();
      chk({expansion_dout, expansion_gain_select_lines, expansion_output_lines}, v[7:0]);
      bus(1'b0, ADDR_EXPAN, 32'h0);
      chk(rd, v[7:0]);
    end
    v = rnd();
    bus(1'b1, ADDR_DOUT, v);
    settle();
    chk({discrete_io_lines_oe, discrete_io_lines_out}, {discrete_io_dir, v[7:0]});
    for (int m = 0; m < 8; m++) conv(m[2:0], m[0]);
    irq_source_external <= 1'b1;
    external_irq <= 1'b1;
    repeat (3) settle();
    external_irq <= 1'b0;
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd[1:0], 2'b10);
    chk(irq, 1'b1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h2);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    irq_source_external <= 1'b0;
    external_trigger <= 1'b1;
    waitdone();
    chk(busy > 0, 1'b1);
    external_trigger <= 1'b0;
    bus(1'b0, ADDR_DIN, 32'h0);
    chk(rd, {24'h0, discrete_io_lines_in});
    // Timer chain: counter one paces counters two and zero and starts a conversion.
    counter_zero_clock_jumper <= 1'b1;
    timer_trigger_position <= 1'b1;
    bus(1'b1, ADDR_CNT0, 32'h3);
    bus(1'b1, ADDR_CNT2, 32'h3);
    bus(1'b1, ADDR_CNT1, 32'h2);
    busy = 0;
    while (sample_hold !== 1'b1 && busy < 4000) begin
      @(posedge pclk);
      busy++;
    end
    chk(busy < 4000, 1'b1);
    chk(counter_out[1], 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h1);
    bus(1'b0, ADDR_CNT2, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, ADDR_CNT0, 32'h0);
    chk(rd, 32'h2);
    stop_test();
  end
endmodule
